// ===== hw/spis_irq_gen.sv
// spis_irq_gen: per-port interrupt generation unit; turns one pending
// level into message-signalled events or assert/deassert messages.
// assumes pending and both enables come from logic on the same clock.
`timescale 1ns/1ps
module spis_irq_gen (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pending,
    input wire logic intxDisable,
    input wire logic msiEnable,
    output logic msiSend,
    output logic intxAssert,
    output logic intxDeassert,
    output logic intxActive
);
    spis_pkg::spis_state_type state_q;
    logic pendingPrev_q;
    logic intxOk;

    assign intxOk = !intxDisable && !msiEnable;
    assign intxActive = (state_q == spis_pkg::SPIS_ASSERTED);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pendingPrev_q <= 1'b0;
            msiSend <= 1'b0;
        end else begin
            pendingPrev_q <= pending;
            msiSend <= msiEnable && pending && !pendingPrev_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= spis_pkg::SPIS_IDLE;
            intxAssert <= 1'b0;
            intxDeassert <= 1'b0;
        end else begin
            intxAssert <= 1'b0;
            intxDeassert <= 1'b0;
            unique case (state_q)
                spis_pkg::SPIS_IDLE: begin
                    if (pending && intxOk) begin
                        intxAssert <= 1'b1;
                        state_q <= spis_pkg::SPIS_ASSERTED;
                    end
                end
                spis_pkg::SPIS_ASSERTED: begin
                    if (!pending || !intxOk) begin
                        intxDeassert <= 1'b1;
                        state_q <= spis_pkg::SPIS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // spis_irq_gen

// ===== hw/spis_irq_top.sv
// spis_irq_top: interrupt source collection for one switch port, with its
// apb register file and the port's interrupt generation unit.
// assumes event inputs are one-cycle pulses from logic on sys_clk; the
// presence and gpio pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module spis_irq_top #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] rxDetect,
    input wire logic externalPresenceInput,
    input wire logic attentionPress,
    input wire logic powerFault,
    input wire logic retentionLatchSensorChange,
    input wire logic commandDone,
    input wire logic dllStateChange,
    input wire logic [31:0] eccErrorEvents,
    input wire logic [31:0] errorHandlerEvents,
    input wire logic [spis_pkg::GPIO_NUM-1:0] gpioPins,
    input wire logic [31:0] linkRecoverableEvents,
    input wire logic [31:0] linkFatalEvents,
    input wire logic linkActiveChange,
    input wire logic uncorrMsgDrop,
    input wire logic rxIntxAssert,
    input wire logic rxIntxDeassert,
    input wire logic [1:0] rxIntxLine,
    output logic msiSend,
    output logic intxAssert,
    output logic intxDeassert
);
    if (ADDR_W < 12) begin : g_addr_check
        $error("spis_irq_top: ADDR_W must be at least 12");
    end

    logic [31:0] cmd_q, msi_q, role_q;
    logic [15:0] slotCtl_q;
    logic [4:0] slotSta_q;
    logic dllChg_q, presSync1_q, presSync2_q, presPrev_q;
    logic [31:0] eccFlag_q, eccMask_q, ehFlag_q, ehMask_q;
    logic [15:0] gpioDirLo_q;
    logic [2:0] gpioDirHi_q;
    logic [spis_pkg::GPIO_NUM-1:0] gpioSync1_q, gpioSync2_q, gpioPrev_q, gpioFlag_q;
    logic [15:0] vdb_q, vdbMask_q, ldb_q, ldbMask_q;
    logic [31:0] fatFlag_q, fatMask_q, recFlag_q, recMask_q;
    logic [3:0] sumMask_q;
    logic [1:0] sumSticky_q;
    logic [3:0] rxWires_q;
    logic [31:0] rdData;
    logic [3:0] sumFlags;
    logic [spis_pkg::GPIO_NUM-1:0] gpioIsInt;
    logic hit, wrEn, presState, pending, intxActive;
    logic hpReq, eccReq, ovfReq, ehReq, gpioReq, recReq, fatReq, dlaReq, dropReq;
    logic vdbReq, ldbReq, rxReq;

    // access phase takes two cycles: pready rises on its first edge
    assign wrEn = psel && penable && pready && pwrite;

    function automatic logic wrAt(input logic [11:0] ofs);
        // shift keeps the upper-bit test legal when ADDR_W is exactly 12
        wrAt = wrEn && (paddr[11:0] == ofs) && ((paddr >> 12) == '0);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            // error response stands only beside its own pready
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdData;
            end
        end
    end

    // pin synchronisers; only second stages feed logic
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            presSync1_q <= 1'b0;
            presSync2_q <= 1'b0;
            gpioSync1_q <= '0;
            gpioSync2_q <= '0;
        end else begin
            presSync1_q <= externalPresenceInput;
            presSync2_q <= presSync1_q;
            gpioSync1_q <= gpioPins;
            gpioSync2_q <= gpioSync1_q;
        end
    end

    assign presState = (|rxDetect) || presSync2_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_q <= 32'h0000_0000;
            msi_q <= 32'h0000_0000;
            role_q <= {29'h0000_0000, spis_pkg::ROLE_RESET};
        end else begin
            if (wrAt(spis_pkg::CMD_OFS)) begin
                cmd_q[spis_pkg::CMD_INTDIS_BIT] <= pwdata[spis_pkg::CMD_INTDIS_BIT];
            end
            if (wrAt(spis_pkg::MSI_OFS)) begin
                msi_q[spis_pkg::MSI_EN_BIT] <= pwdata[spis_pkg::MSI_EN_BIT];
            end
            if (wrAt(spis_pkg::ROLE_OFS)) begin
                role_q[2:0] <= pwdata[2:0];
            end
        end
    end

    // slot: control low half, sticky status high half, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slotCtl_q <= 16'h0000;
            slotSta_q <= 5'h00;
            dllChg_q <= 1'b0;
            presPrev_q <= 1'b0;
        end else begin
            presPrev_q <= presState;
            if (wrAt(spis_pkg::SLOT_OFS)) begin
                slotCtl_q <= pwdata[15:0];
                slotSta_q <= slotSta_q & ~pwdata[spis_pkg::SLOT_STAT_LSB +: 5]
                    | {commandDone, presState != presPrev_q, retentionLatchSensorChange,
                    powerFault, attentionPress};
                dllChg_q <= (dllChg_q && !pwdata[spis_pkg::SLOT_DLL_CHG_BIT]) || dllStateChange;
            end else begin
                slotSta_q <= slotSta_q | {commandDone, presState != presPrev_q,
                    retentionLatchSensorChange, powerFault, attentionPress};
                dllChg_q <= dllChg_q || dllStateChange;
            end
        end
    end

    // egress ECC and error handler flags; inputs land on their assigned bits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            eccFlag_q <= 32'h0000_0000;
            eccMask_q <= spis_pkg::MASK_RESET;
            ehFlag_q <= 32'h0000_0000;
            ehMask_q <= spis_pkg::MASK_RESET;
        end else begin
            eccFlag_q <= (eccFlag_q & ~(wrAt(spis_pkg::ECC_FLAG_OFS) ? pwdata : 32'h0000_0000))
                | eccErrorEvents;
            ehFlag_q <= (ehFlag_q & ~(wrAt(spis_pkg::EH_FLAG_OFS) ? pwdata : 32'h0000_0000))
                | errorHandlerEvents;
            if (wrAt(spis_pkg::ECC_MASK_OFS)) begin
                eccMask_q <= pwdata;
            end
            if (wrAt(spis_pkg::EH_MASK_OFS)) begin
                ehMask_q <= pwdata;
            end
        end
    end

    assign gpioIsInt = {gpioDirHi_q, gpioDirLo_q};

    // gpio: a rising edge on a pin configured as interrupt input sets its flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gpioDirLo_q <= 16'h0000;
            gpioDirHi_q <= 3'h0;
            gpioPrev_q <= '0;
            gpioFlag_q <= '0;
        end else begin
            gpioPrev_q <= gpioSync2_q;
            if (wrAt(spis_pkg::GPIO_LO_OFS)) begin
                gpioDirLo_q <= pwdata[15:0];
            end
            if (wrAt(spis_pkg::GPIO_HI_OFS)) begin
                gpioDirHi_q <= pwdata[2:0];
            end
            gpioFlag_q <= (gpioFlag_q & ~(wrAt(spis_pkg::GPIO_FLAG_OFS)
                ? pwdata[spis_pkg::GPIO_NUM-1:0] : '0))
                | (gpioSync2_q & ~gpioPrev_q & gpioIsInt);
        end
    end

    // doorbells: separate set and clear addresses for request and mask
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vdb_q <= 16'h0000;
            ldb_q <= 16'h0000;
            vdbMask_q <= spis_pkg::DB_MASK_RESET;
            ldbMask_q <= spis_pkg::DB_MASK_RESET;
        end else begin
            if (wrAt(spis_pkg::VDB_SET_OFS)) vdb_q <= vdb_q | pwdata[15:0];
            if (wrAt(spis_pkg::VDB_CLR_OFS)) vdb_q <= vdb_q & ~pwdata[15:0];
            if (wrAt(spis_pkg::VDB_MSET_OFS)) vdbMask_q <= vdbMask_q | pwdata[15:0];
            if (wrAt(spis_pkg::VDB_MCLR_OFS)) vdbMask_q <= vdbMask_q & ~pwdata[15:0];
            if (wrAt(spis_pkg::LDB_SET_OFS)) ldb_q <= ldb_q | pwdata[15:0];
            if (wrAt(spis_pkg::LDB_CLR_OFS)) ldb_q <= ldb_q & ~pwdata[15:0];
            if (wrAt(spis_pkg::LDB_MSET_OFS)) ldbMask_q <= ldbMask_q | pwdata[15:0];
            if (wrAt(spis_pkg::LDB_MCLR_OFS)) ldbMask_q <= ldbMask_q & ~pwdata[15:0];
        end
    end

    // isolated link side errors and their summary
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fatFlag_q <= 32'h0000_0000;
            recFlag_q <= 32'h0000_0000;
            fatMask_q <= spis_pkg::MASK_RESET;
            recMask_q <= spis_pkg::MASK_RESET;
            sumMask_q <= 4'h0;
            sumSticky_q <= 2'h0;
        end else begin
            fatFlag_q <= (fatFlag_q & ~(wrAt(spis_pkg::FAT_FLAG_OFS) ? pwdata : 32'h0000_0000))
                | linkFatalEvents;
            recFlag_q <= (recFlag_q & ~(wrAt(spis_pkg::REC_FLAG_OFS) ? pwdata : 32'h0000_0000))
                | linkRecoverableEvents;
            sumSticky_q <= (sumSticky_q & ~(wrAt(spis_pkg::SUM_FLAG_OFS)
                ? pwdata[spis_pkg::SUM_DROP_BIT:spis_pkg::SUM_DLA_BIT] : 2'h0))
                | {uncorrMsgDrop, linkActiveChange};
            if (wrAt(spis_pkg::FAT_MASK_OFS)) fatMask_q <= pwdata;
            if (wrAt(spis_pkg::REC_MASK_OFS)) recMask_q <= pwdata;
            if (wrAt(spis_pkg::SUM_MASK_OFS)) sumMask_q <= pwdata[3:0];
        end
    end

    assign sumFlags = {sumSticky_q, |fatFlag_q, |recFlag_q};

    // received legacy virtual wires: one level per line, assert wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxWires_q <= 4'h0;
        end else if (rxIntxAssert) begin
            rxWires_q[rxIntxLine] <= 1'b1;
        end else if (rxIntxDeassert) begin
            rxWires_q[rxIntxLine] <= 1'b0;
        end
    end

    // source requests; ecc, error handler, link error and doorbell requests pass only where their mask is clear
    always_comb begin
        hpReq = role_q[spis_pkg::ROLE_DS_BIT] && slotCtl_q[spis_pkg::SLOT_MASTER_BIT]
            && ((|(slotSta_q & {slotCtl_q[spis_pkg::SLOT_CMDDONE_EN_BIT], slotCtl_q[3:0]}))
            || dllChg_q);
        eccReq = |(eccFlag_q & ~eccMask_q);
        ovfReq = ehFlag_q[spis_pkg::EH_OVF_BIT] && !ehMask_q[spis_pkg::EH_OVF_BIT];
        ehReq = |(ehFlag_q[spis_pkg::EH_HI_BIT:spis_pkg::EH_LO_BIT]
            & ~ehMask_q[spis_pkg::EH_HI_BIT:spis_pkg::EH_LO_BIT]);
        gpioReq = role_q[spis_pkg::ROLE_UP_BIT] && (|gpioFlag_q);
        recReq = role_q[spis_pkg::ROLE_ISO_BIT] && !sumMask_q[spis_pkg::SUM_REC_BIT]
            && (|(recFlag_q & ~recMask_q));
        fatReq = role_q[spis_pkg::ROLE_ISO_BIT] && !sumMask_q[spis_pkg::SUM_FAT_BIT]
            && (|(fatFlag_q & ~fatMask_q));
        dlaReq = role_q[spis_pkg::ROLE_ISO_BIT] && sumSticky_q[0]
            && !sumMask_q[spis_pkg::SUM_DLA_BIT];
        dropReq = role_q[spis_pkg::ROLE_ISO_BIT] && sumSticky_q[1]
            && !sumMask_q[spis_pkg::SUM_DROP_BIT];
        vdbReq = |(vdb_q & ~vdbMask_q);
        ldbReq = |(ldb_q & ~ldbMask_q);
        rxReq = |rxWires_q;
    end

    assign pending = hpReq || eccReq || ovfReq || ehReq || gpioReq || recReq || fatReq
        || dlaReq || dropReq || vdbReq || ldbReq || rxReq;

    spis_irq_gen u_gen (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pending(pending),
        .intxDisable(cmd_q[spis_pkg::CMD_INTDIS_BIT]),
        .msiEnable(msi_q[spis_pkg::MSI_EN_BIT]),
        .msiSend(msiSend),
        .intxAssert(intxAssert),
        .intxDeassert(intxDeassert),
        .intxActive(intxActive)
    );

    always_comb begin
        rdData = 32'h0000_0000;
        hit = ((paddr >> 12) == '0);
        unique case (paddr[11:0])
            spis_pkg::CMD_OFS: begin
                rdData[spis_pkg::CMD_INTDIS_BIT] = cmd_q[spis_pkg::CMD_INTDIS_BIT];
                rdData[spis_pkg::CMD_INTSTAT_BIT] = pending || intxActive;
            end
            spis_pkg::MSI_OFS: rdData[spis_pkg::MSI_EN_BIT] = msi_q[spis_pkg::MSI_EN_BIT];
            spis_pkg::SLOT_OFS: begin
                rdData[15:0] = slotCtl_q;
                rdData[spis_pkg::SLOT_STAT_LSB +: 5] = slotSta_q;
                rdData[spis_pkg::SLOT_PRES_STATE_BIT] = presState;
                rdData[spis_pkg::SLOT_DLL_CHG_BIT] = dllChg_q;
            end
            spis_pkg::ECC_FLAG_OFS: rdData = eccFlag_q;
            spis_pkg::ECC_MASK_OFS: rdData = eccMask_q;
            spis_pkg::EH_FLAG_OFS: rdData = ehFlag_q;
            spis_pkg::EH_MASK_OFS: rdData = ehMask_q;
            spis_pkg::GPIO_LO_OFS: rdData[15:0] = gpioDirLo_q;
            spis_pkg::GPIO_HI_OFS: rdData[2:0] = gpioDirHi_q;
            spis_pkg::GPIO_FLAG_OFS: rdData[spis_pkg::GPIO_NUM-1:0] = gpioFlag_q;
            spis_pkg::ROLE_OFS: rdData[2:0] = role_q[2:0];
            spis_pkg::VDB_SET_OFS, spis_pkg::VDB_CLR_OFS: rdData[15:0] = vdb_q;
            spis_pkg::VDB_MSET_OFS, spis_pkg::VDB_MCLR_OFS: rdData[15:0] = vdbMask_q;
            spis_pkg::LDB_SET_OFS, spis_pkg::LDB_CLR_OFS: rdData[15:0] = ldb_q;
            spis_pkg::LDB_MSET_OFS, spis_pkg::LDB_MCLR_OFS: rdData[15:0] = ldbMask_q;
            spis_pkg::FAT_FLAG_OFS: rdData = fatFlag_q;
            spis_pkg::FAT_MASK_OFS: rdData = fatMask_q;
            spis_pkg::REC_FLAG_OFS: rdData = recFlag_q;
            spis_pkg::REC_MASK_OFS: rdData = recMask_q;
            spis_pkg::SUM_FLAG_OFS: rdData[3:0] = sumFlags;
            spis_pkg::SUM_MASK_OFS: rdData[3:0] = sumMask_q;
            default: hit = 1'b0;
        endcase
    end
endmodule // spis_irq_top

// ===== hw/spis_pkg.sv
// spis_pkg: offsets, field positions, reset values and states of the
// switch port interrupt source block.
// assumes a 12-bit byte address on a 32-bit apb register bus.
package spis_pkg;
    localparam logic [11:0] CMD_OFS = 12'h004;
    localparam logic [11:0] MSI_OFS = 12'h048;
    localparam logic [11:0] SLOT_OFS = 12'h080;
    localparam logic [11:0] ECC_FLAG_OFS = 12'h1c0;
    localparam logic [11:0] ECC_MASK_OFS = 12'h1c4;
    localparam logic [11:0] EH_FLAG_OFS = 12'h1cc;
    localparam logic [11:0] EH_MASK_OFS = 12'h1d0;
    localparam logic [11:0] GPIO_LO_OFS = 12'h62c;
    localparam logic [11:0] GPIO_HI_OFS = 12'h630;
    localparam logic [11:0] GPIO_FLAG_OFS = 12'h634;
    localparam logic [11:0] ROLE_OFS = 12'h700;
    localparam logic [11:0] VDB_SET_OFS = 12'hc4c;
    localparam logic [11:0] VDB_CLR_OFS = 12'hc50;
    localparam logic [11:0] VDB_MSET_OFS = 12'hc54;
    localparam logic [11:0] VDB_MCLR_OFS = 12'hc58;
    localparam logic [11:0] LDB_SET_OFS = 12'hc5c;
    localparam logic [11:0] LDB_CLR_OFS = 12'hc60;
    localparam logic [11:0] LDB_MSET_OFS = 12'hc64;
    localparam logic [11:0] LDB_MCLR_OFS = 12'hc68;
    localparam logic [11:0] FAT_FLAG_OFS = 12'hfb8;
    localparam logic [11:0] FAT_MASK_OFS = 12'hfbc;
    localparam logic [11:0] REC_FLAG_OFS = 12'hfc4;
    localparam logic [11:0] REC_MASK_OFS = 12'hfc8;
    localparam logic [11:0] SUM_FLAG_OFS = 12'hfe0;
    localparam logic [11:0] SUM_MASK_OFS = 12'hfe4;

    localparam int CMD_INTDIS_BIT = 10;
    localparam int CMD_INTSTAT_BIT = 19;
    localparam int MSI_EN_BIT = 16;
    localparam int SLOT_MASTER_BIT = 5;
    localparam int SLOT_CMDDONE_EN_BIT = 12;
    localparam int SLOT_STAT_LSB = 16;
    localparam int SLOT_PRES_CHG_BIT = 19;
    localparam int SLOT_PRES_STATE_BIT = 22;
    localparam int SLOT_DLL_CHG_BIT = 24;
    localparam int EH_OVF_BIT = 0;
    localparam int EH_LO_BIT = 4;
    localparam int EH_HI_BIT = 26;
    localparam int EH_RETRY_SBE_BIT = 12;
    localparam int EH_RETRY_DBE_BIT = 13;
    localparam int SUM_REC_BIT = 0;
    localparam int SUM_FAT_BIT = 1;
    localparam int SUM_DLA_BIT = 2;
    localparam int SUM_DROP_BIT = 3;
    localparam int ROLE_UP_BIT = 0;
    localparam int ROLE_DS_BIT = 1;
    localparam int ROLE_ISO_BIT = 2;
    localparam int GPIO_NUM = 19;
    localparam int DB_NUM = 16;

    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [15:0] DB_MASK_RESET = 16'hffff;
    localparam logic [2:0] ROLE_RESET = 3'h2;

    typedef enum logic [0:0] {
        SPIS_IDLE = 1'b0,
        SPIS_ASSERTED = 1'b1
    } spis_state_type;
endpackage

// ===== tb/spis_host_model.sv
// spis_host_model: upstream host; counts messages and tracks the line.
// assumes messages are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module spis_host_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic msiSend,
    input wire logic intxAssert,
    input wire logic intxDeassert,
    output int msiCount,
    output int assertCount,
    output int deassertCount,
    output logic lineLevel
);
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            {msiCount, assertCount, deassertCount, lineLevel} <= '0;
        end else begin
            msiCount <= msiCount + int'(msiSend);
            assertCount <= assertCount + int'(intxAssert);
            deassertCount <= deassertCount + int'(intxDeassert);
            lineLevel <= intxAssert | (lineLevel & ~intxDeassert);
        end
    end
endmodule // spis_host_model

// ===== tb/spis_irq_top_props.sv
// spis_irq_top_props: port-level checks of the interrupt source block.
// assumes it is bound to spis_irq_top and sees only its ports.
`timescale 1ns/1ps
module spis_irq_top_props #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic msiSend,
    input wire logic intxAssert,
    input wire logic intxDeassert
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic lineHigh_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || intxDeassert) begin
            lineHigh_q <= 1'b0;
        end else if (intxAssert) begin
            lineHigh_q <= 1'b1;
        end
    end
    property p_ready_two; psel && penable && !pready |=> pready; endproperty
    a_ready_two: assert property (p_ready_two) else $error("pready late");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready too long");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("pready without access");
    property p_unmapped; psel && penable && !pready && paddr == '0 |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    property p_assert_order; intxAssert |-> !lineHigh_q && !intxDeassert; endproperty
    a_assert_order: assert property (p_assert_order) else $error("double assert");
    property p_deassert_order; intxDeassert |-> lineHigh_q; endproperty
    a_deassert_order: assert property (p_deassert_order) else $error("stray deassert");
    property p_msi_pulse; msiSend |=> !msiSend; endproperty
    a_msi_pulse: assert property (p_msi_pulse) else $error("msi not a pulse");
    property p_exclusive; msiSend |-> !intxAssert; endproperty
    a_exclusive: assert property (p_exclusive) else $error("both paths");
    c_assert: cover property (intxAssert);
    c_msi: cover property (msiSend);
    c_err: cover property (pslverr);
endmodule // spis_irq_top_props
bind spis_irq_top spis_irq_top_props #(.ADDR_W(ADDR_W)) i_spis_irq_top_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .msiSend(msiSend), .intxAssert(intxAssert),
    .intxDeassert(intxDeassert));

// ===== tb/spis_irq_top_test.sv
// spis_irq_top_test: register, hot-plug, error and message-path checks.
// assumes the host model counts every message leaving the port.
`timescale 1ns/1ps
module spis_irq_top_test;
    typedef struct {logic [31:0] ctl; int src; logic [31:0] stat; int hits;} spis_row_type;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, extPres, err, lineLevel;
    logic msiSend, intxAssert, intxDeassert;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ecc, eh;
    logic [4:0] hp;
    logic [1:0] rxDet, rxMsg, rxLine;
    logic [18:0] gpio;
    int n_errors, compares, msiCount, assertCount, deassertCount, expA, expD, expM;
    spis_row_type rows [7];
    logic [11:0] ra [9] = '{12'h1c4, 12'h1d0, 12'hfbc, 12'hfc8, 12'hfe4, 12'hc54, 12'hc64,
        12'h700, 12'h000};
    logic [31:0] rv [9] = '{0, 0, 0, 0, 0, 32'hffff, 32'hffff, 32'h2, 0};
    spis_irq_top #(.ADDR_W(12)) i_spis_irq_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxDetect(rxDet),
        .externalPresenceInput(extPres), .attentionPress(hp[0]), .powerFault(hp[1]),
        .retentionLatchSensorChange(hp[2]), .commandDone(hp[3]), .dllStateChange(hp[4]),
        .eccErrorEvents(ecc), .errorHandlerEvents(eh), .gpioPins(gpio),
        .linkRecoverableEvents(32'h0), .linkFatalEvents(32'h0), .linkActiveChange(1'b0),
        .uncorrMsgDrop(1'b0), .rxIntxAssert(rxMsg[0]), .rxIntxDeassert(rxMsg[1]),
        .rxIntxLine(rxLine), .msiSend(msiSend), .intxAssert(intxAssert),
        .intxDeassert(intxDeassert));
    spis_host_model i_spis_host_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .msiSend(msiSend), .intxAssert(intxAssert), .intxDeassert(intxDeassert),
        .msiCount(msiCount), .assertCount(assertCount), .deassertCount(deassertCount),
        .lineLevel(lineLevel));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin
            n_errors++;
            $display("Error at %0t: no pready", $time);
            final_report();
        end
    endtask
    task automatic settle();
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [31:0] e, input logic [31:0] h, input logic [4:0] p,
        input logic [1:0] m);
        ecc <= e; eh <= h; hp <= p; rxMsg <= m;
        @(posedge sys_clk);
        ecc <= '0; eh <= '0; hp <= '0; rxMsg <= '0;
        settle();
    endtask
    task automatic counts();
        check(32'(assertCount), 32'(expA));
        check(32'(deassertCount), 32'(expD));
        check(32'(msiCount), 32'(expM));
        check({31'h0, lineLevel}, {31'h0, expA != expD});
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, extPres, hp, rxDet, ecc, eh, rxMsg, gpio} = '0;
        {n_errors, compares, expA, expD, expM} = '0;
        rxLine = 2'b11;
        rows = '{'{32'h21, 0, 32'h10000, 1}, '{32'h22, 1, 32'h20000, 1},
            '{32'h24, 2, 32'h40000, 1}, '{32'h1020, 3, 32'h100000, 1},
            '{32'h20, 4, 32'h1000000, 1}, '{32'h01, 0, 32'h10000, 0}, '{32'h20, 0, 32'h10000, 0}};
        sys_rst = 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 0);
            check(rd, rv[i]);
            check({31'h0, err}, {31'h0, ra[i] == 12'h000});
        end
        foreach (rows[i]) begin
            apb(1'b1, 12'h080, rows[i].ctl);
            pulse(0, 0, 5'(1 << rows[i].src), 0);
            expA += rows[i].hits;
            apb(1'b0, 12'h080, 0);
            check(rd & 32'h011f0000, rows[i].stat);
            apb(1'b1, 12'h080, rows[i].ctl | rows[i].stat);
            settle();
            expD += rows[i].hits;
            counts();
        end
        rxDet <= 2'b01;
        settle();
        apb(1'b0, 12'h080, 0);
        check(rd & 32'h00480000, 32'h00480000);
        extPres <= 1'b1;
        settle();
        rxDet <= 2'b00;
        settle();
        apb(1'b0, 12'h080, 0);
        check(rd & 32'h00400000, 32'h00400000);
        apb(1'b1, 12'h1c4, 32'h1);
        pulse(32'h1, 0, 0, 0);
        counts();
        apb(1'b0, 12'h1c0, 0);
        check(rd, 32'h1);
        pulse(32'h4, 0, 0, 0);
        expA++;
        counts();
        apb(1'b1, 12'h1c0, 32'hffffffff);
        settle();
        expD++;
        counts();
        apb(1'b1, 12'h048, 32'h10000);
        pulse(0, 32'h1000, 0, 0);
        expM++;
        counts();
        apb(1'b0, 12'h1cc, 0);
        check(rd, 32'h1000);
        apb(1'b1, 12'h1cc, 32'hffffffff);
        apb(1'b1, 12'h048, 0);
        apb(1'b1, 12'h004, 32'h400);
        pulse(0, 32'h1, 0, 0);
        counts();
        apb(1'b0, 12'h004, 0);
        check(rd & 32'h80400, 32'h80400);
        apb(1'b1, 12'h1cc, 32'hffffffff);
        apb(1'b1, 12'h004, 0);
        pulse(0, 0, 0, 2'b01);
        expA++;
        counts();
        pulse(0, 0, 0, 2'b10);
        expD++;
        counts();
        // only pin 0 is an interrupt input; pin 1 must leave no flag behind
        apb(1'b1, 12'h700, 32'h3);
        apb(1'b1, 12'h62c, 32'h1);
        gpio <= 19'h3;
        settle();
        settle();
        expA++;
        counts();
        apb(1'b1, 12'h634, 32'h1);
        settle();
        expD++;
        counts();
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'hc4c + 12'(k * 16), 32'h1);
            settle();
            counts();
            apb(1'b1, 12'hc58 + 12'(k * 16), 32'h1);
            settle();
            expA++;
            counts();
            apb(1'b1, 12'hc50 + 12'(k * 16), 32'h1);
            settle();
            expD++;
            counts();
        end
        final_report();
    end
endmodule // spis_irq_top_test
